// >>> core/mie_pkg.sv
/*
  Shared constants and types of the instruction execute core: register
  offsets, field positions, opcodes, flag layout and timing counts.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package mie_pkg;

  // register byte offsets, one aligned word each
  localparam logic [4:0] OFF_INSTR    = 5'h00;
  localparam logic [4:0] OFF_ACC      = 5'h04;
  localparam logic [4:0] OFF_STATUS   = 5'h08;
  localparam logic [4:0] OFF_PC       = 5'h0C;
  localparam logic [4:0] OFF_MEM_ADDR = 5'h10;
  localparam logic [4:0] OFF_MEM_DATA = 5'h14;
  localparam logic [4:0] OFF_STACK    = 5'h18;

  // status register field positions
  localparam int STAT_FLAGS_MSB = 5;
  localparam int STAT_BUSY      = 8;
  localparam int STAT_HALTED    = 9;
  localparam int STAT_PRE_FIRST = 10;
  localparam int STAT_PRE_SECND = 11;
  localparam int STACK_CNT_LSB  = 16;

  // widths and reset values
  localparam int         RAM_AW       = 6;
  localparam int         PC_W         = 11;
  localparam logic [7:0] ACC_RESET    = 8'h00;
  localparam logic [5:0] FLAGS_RESET  = 6'h00;
  localparam logic [5:0] PC_LOW_INDEX = 6'h06;

  // one instruction cycle is four system clocks
  localparam int         CLKS_PER_ICYCLE = 4;
  localparam logic [3:0] CLKS_SHORT      = 4'(CLKS_PER_ICYCLE);
  localparam logic [3:0] CLKS_LONG       = 4'(2 * CLKS_PER_ICYCLE);

  // decimal adjust constants
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_FIX   = 5'h06;

  // opcodes carried in the instruction word
  localparam logic [4:0] OP_NOP             = 5'h00;
  localparam logic [4:0] OP_ADD_CARRY_ACC   = 5'h01;
  localparam logic [4:0] OP_ADD_CARRY_MEM   = 5'h02;
  localparam logic [4:0] OP_ADD_ACC         = 5'h03;
  localparam logic [4:0] OP_ADD_IMM         = 5'h04;
  localparam logic [4:0] OP_SUM_INTO_MEMORY = 5'h05;
  localparam logic [4:0] OP_AND_ACC         = 5'h06;
  localparam logic [4:0] OP_AND_IMM         = 5'h07;
  localparam logic [4:0] OP_CONJ_INTO_MEM   = 5'h08;
  localparam logic [4:0] OP_CALL            = 5'h09;
  localparam logic [4:0] OP_ZERO_MEMORY     = 5'h0A;
  localparam logic [4:0] OP_BIT_ZERO        = 5'h0B;
  localparam logic [4:0] OP_WD_RESTART      = 5'h0C;
  localparam logic [4:0] OP_WD_PRE_FIRST    = 5'h0D;
  localparam logic [4:0] OP_WD_PRE_SECOND   = 5'h0E;
  localparam logic [4:0] OP_INVERT_MEMORY   = 5'h0F;
  localparam logic [4:0] OP_INVERT_INTO_ACC = 5'h10;
  localparam logic [4:0] OP_DECIMAL_ADJUST  = 5'h11;
  localparam logic [4:0] OP_COUNT_DOWN_MEM  = 5'h12;
  localparam logic [4:0] OP_COUNT_DOWN_ACC  = 5'h13;
  localparam logic [4:0] OP_POWER_DOWN      = 5'h14;

  // instruction word as written to the instruction register
  typedef struct packed {
    logic [4:0]  opcode;
    logic [2:0]  bit_sel;
    logic [4:0]  spare;
    logic [10:0] operand;
  } mie_instr_t;

  // status flags, low six bits of the status register
  typedef struct packed {
    logic power_down_flag;
    logic watchdog_expired_flag;
    logic signed_wrap_flag;
    logic result_null_flag;
    logic nibble_spill_flag;
    logic arith_spill_flag;
  } mie_flags_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} mie_state_t;

endpackage

// >>> core/mie_core.sv
/*
  Instruction execute core: runs one instruction at a time written by
  software into the instruction register, against its own accumulator,
  data memory, program counter, return stack and status flags.
  Assumes a same-clock watchdog counter beside it (wdt_timeout in,
  wdt_clear out) and an asynchronous wake pin.
*/
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
// Notes on behaviour
// - add with carry, result into accumulator
// - add with carry, result into memory
// - add memory to accumulator, no carry
// - add immediate constant to accumulator
// - add accumulator into memory, no carry
// - and with memory, only null flag
// - and with immediate, only null flag
// - and into memory, only null flag
// - call pushes next pc, jumps, flags kept
// - zero memory byte, flags kept
// - clear one selected bit, flags kept
// - watchdog restart clears counter and two flags
// - second preclear of pair restarts watchdog
// - lone preclear only records itself
// - invert memory byte in place, null flag
// - inverted byte into accumulator, null flag
// - decimal adjust nibbles with six, sets carry
// - adjusted value into memory, carry only
// - memory minus one in place, null flag
// - memory minus one into accumulator
// - power down stops execution, keeps state
// - power down restarts watchdog, sets flag
// - pc low write adds one instruction cycle
`timescale 1ns/10ps

module mie_core
  import mie_pkg::*;
#(
  parameter int RAM_DEPTH   = 64,
  parameter int STACK_DEPTH = 6
)(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        wake_pin,
  input  wire logic        wdt_timeout,
  output logic             wdt_clear,
  output logic             clock_stop
);
  import mie_pkg::*;

  // the pc low index must exist and the ram index is a masked address
  if (RAM_DEPTH < 8 || RAM_DEPTH > 64 || (RAM_DEPTH & (RAM_DEPTH - 1)) != 0)
  begin : g_bad_ram
    $error("RAM_DEPTH must be a power of two from 8 to 64");
  end
  if (STACK_DEPTH < 1 || STACK_DEPTH > 8)
  begin : g_bad_stack
    $error("STACK_DEPTH must lie between 1 and 8");
  end

  function automatic logic [RAM_AW-1:0] ram_index(input logic [RAM_AW-1:0] a);
    ram_index = a & RAM_AW'(RAM_DEPTH - 1);
  endfunction

  logic [7:0]        ram [RAM_DEPTH];
  logic [PC_W-1:0]   stack [STACK_DEPTH];
  logic [2:0]        sp;
  logic [7:0]        acc;
  mie_flags_t        flags;
  logic [PC_W-1:0]   pc;
  logic [RAM_AW-1:0] mem_addr;
  mie_instr_t        instr;
  mie_state_t        state;
  logic [3:0]        clk_cnt;
  logic              pre_first_seen;
  logic              pre_second_seen;
  logic              rd_done;
  logic              wake_meta;
  logic              wake_sync;

  // bus decode; a read answers one clock later from a flop
  wire       busy       = (state == ST_EXEC);
  assign     waitrequest = ((read | write) & busy) | (read & ~rd_done);
  wire       wr_ok      = write & ~waitrequest;
  wire       wr_instr   = wr_ok & (address == OFF_INSTR) & (&byteenable[2:0])
                          & (state == ST_IDLE);
  wire       wr_acc     = wr_ok & (address == OFF_ACC) & byteenable[0];
  wire       wr_status  = wr_ok & (address == OFF_STATUS) & byteenable[0];
  wire       wr_pc      = wr_ok & (address == OFF_PC);
  wire       wr_maddr   = wr_ok & (address == OFF_MEM_ADDR) & byteenable[0];
  wire       wr_mdata   = wr_ok & (address == OFF_MEM_DATA) & byteenable[0];
  wire [2:0] sp_top     = (sp == 3'd0) ? 3'(STACK_DEPTH - 1) : sp - 3'd1;

  // operands of the latched instruction
  wire [4:0]        op      = instr.opcode;
  wire [RAM_AW-1:0] m_addr  = ram_index(instr.operand[RAM_AW-1:0]);
  wire [7:0]        m_val   = ram[m_addr];
  wire [7:0]        imm     = instr.operand[7:0];
  wire              use_imm = (op == OP_ADD_IMM) | (op == OP_AND_IMM);
  wire [7:0]        opnd_b  = use_imm ? imm : m_val;
  wire              cin     = flags.arith_spill_flag
                              & ((op == OP_ADD_CARRY_ACC) | (op == OP_ADD_CARRY_MEM));

  // adder with nibble carry, carry out and signed overflow
  wire [4:0] lo_sum  = {1'b0, acc[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
  wire [8:0] add_sum = {1'b0, acc} + {1'b0, opnd_b} + {8'h00, cin};
  wire       add_ovf = (acc[7] == opnd_b[7]) & (add_sum[7] != acc[7]);

  // decimal adjust of the accumulator, nibble by nibble
  wire       lo_fix = ({1'b0, acc[3:0]} > BCD_LIMIT) | flags.nibble_spill_flag;
  wire [4:0] lo_adj = {1'b0, acc[3:0]} + (lo_fix ? BCD_FIX : 5'h00);
  wire       nib_in = lo_adj[4];
  wire [4:0] hi_pre = {1'b0, acc[7:4]} + {4'h0, nib_in};
  wire       hi_fix = (hi_pre > BCD_LIMIT) | flags.arith_spill_flag;
  wire [4:0] hi_adj = hi_pre + (hi_fix ? BCD_FIX : 5'h00);

  // result selection per opcode
  logic [7:0] res;
  logic       dest_acc;
  logic       dest_mem;
  logic       upd_arith;
  logic       upd_null;
  always_comb
  begin
    res       = 8'h00;
    dest_acc  = 1'b0;
    dest_mem  = 1'b0;
    upd_arith = 1'b0;
    upd_null  = 1'b0;
    unique case (op)
      OP_ADD_CARRY_ACC, OP_ADD_ACC, OP_ADD_IMM:
      begin
        res = add_sum[7:0]; dest_acc = 1'b1; upd_arith = 1'b1;
      end
      OP_ADD_CARRY_MEM, OP_SUM_INTO_MEMORY:
      begin
        res = add_sum[7:0]; dest_mem = 1'b1; upd_arith = 1'b1;
      end
      OP_AND_ACC, OP_AND_IMM:
      begin
        res = acc & opnd_b; dest_acc = 1'b1; upd_null = 1'b1;
      end
      OP_CONJ_INTO_MEM:
      begin
        res = acc & m_val; dest_mem = 1'b1; upd_null = 1'b1;
      end
      OP_ZERO_MEMORY:
      begin
        res = 8'h00; dest_mem = 1'b1;
      end
      OP_BIT_ZERO:
      begin
        res = m_val & ~(8'h01 << instr.bit_sel); dest_mem = 1'b1;
      end
      OP_INVERT_MEMORY:
      begin
        res = ~m_val; dest_mem = 1'b1; upd_null = 1'b1;
      end
      OP_INVERT_INTO_ACC:
      begin
        res = ~m_val; dest_acc = 1'b1; upd_null = 1'b1;
      end
      OP_DECIMAL_ADJUST:
      begin
        res = {hi_adj[3:0], lo_adj[3:0]}; dest_mem = 1'b1;
      end
      OP_COUNT_DOWN_MEM:
      begin
        res = m_val - 8'h01; dest_mem = 1'b1; upd_null = 1'b1;
      end
      OP_COUNT_DOWN_ACC:
      begin
        res = m_val - 8'h01; dest_acc = 1'b1; upd_null = 1'b1;
      end
      default:
      begin
        res = 8'h00;
      end
    endcase
  end

  // a memory result aimed at the pc low byte reloads the pc instead
  wire       pc_low_hit = dest_mem & (m_addr == ram_index(PC_LOW_INDEX));
  wire [3:0] total_clks = (pc_low_hit | (op == OP_CALL)) ? CLKS_LONG : CLKS_SHORT;
  wire       exec_done  = busy & (clk_cnt == total_clks - 4'd1);
  wire       pre_pair   = ((op == OP_WD_PRE_FIRST) & pre_second_seen)
                          | ((op == OP_WD_PRE_SECOND) & pre_first_seen);
  wire       wd_restart = exec_done & ((op == OP_WD_RESTART) | pre_pair);
  wire       pwr_down   = exec_done & (op == OP_POWER_DOWN);

  // instruction sequencing; halt stops until wake or watchdog time-out
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin state <= ST_IDLE; clk_cnt <= 4'h0; end
    else
    begin
      unique case (state)
        ST_IDLE: begin clk_cnt <= 4'h0; if (wr_instr) state <= ST_EXEC; end
        ST_EXEC:
        begin
          clk_cnt <= clk_cnt + 4'd1;
          if (exec_done) state <= pwr_down ? ST_HALT : ST_IDLE;
        end
        ST_HALT: if (wake_sync | wdt_timeout) state <= ST_IDLE;
      endcase
    end
  end
  assign clock_stop = (state == ST_HALT);

  // wake pin comes from outside the clock domain
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin wake_meta <= 1'b0; wake_sync <= 1'b0; end
    else begin wake_meta <= wake_pin; wake_sync <= wake_meta; end
  end

  // instruction latch and accumulator
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin instr <= '0; acc <= ACC_RESET; end
    else
    begin
      if (wr_instr) instr <= mie_instr_t'(writedata[23:0]);
      if (wr_acc) acc <= writedata[7:0];
      else if (exec_done & dest_acc) acc <= res;
    end
  end

  // status flags in one process, so the struct has a single driver;
  // software may preset the low four, and a time-out in the restart
  // cycle still sets its flag so a late expiry is never lost
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) flags <= FLAGS_RESET;
    else
    begin
      flags.watchdog_expired_flag <= wdt_timeout | (flags.watchdog_expired_flag & ~wd_restart);
      if (pwr_down) flags.power_down_flag <= 1'b1;
      else if (wd_restart) flags.power_down_flag <= 1'b0;
      if (wr_status) flags[3:0] <= writedata[3:0];
      else if (exec_done & upd_arith)
      begin
        flags.signed_wrap_flag  <= add_ovf;
        flags.result_null_flag  <= (add_sum[7:0] == 8'h00);
        flags.nibble_spill_flag <= lo_sum[4];
        flags.arith_spill_flag  <= add_sum[8];
      end
      else if (exec_done & upd_null) flags.result_null_flag <= (res == 8'h00);
      else if (exec_done & (op == OP_DECIMAL_ADJUST))
        flags.arith_spill_flag <= flags.arith_spill_flag | hi_fix;
    end
  end

  // restart pulse to the watchdog counter, one clock wide
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) wdt_clear <= 1'b0;
    else wdt_clear <= wd_restart | pwr_down;
  end

  // preclear pair tracking; a lone preclear only records itself
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin pre_first_seen <= 1'b0; pre_second_seen <= 1'b0; end
    else if (wd_restart) begin pre_first_seen <= 1'b0; pre_second_seen <= 1'b0; end
    else if (exec_done & (op == OP_WD_PRE_FIRST)) pre_first_seen <= 1'b1;
    else if (exec_done & (op == OP_WD_PRE_SECOND)) pre_second_seen <= 1'b1;
  end

  // program counter, call stack and memory pointer
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin pc <= '0; sp <= 3'd0; mem_addr <= '0; end
    else
    begin
      if (wr_maddr) mem_addr <= writedata[RAM_AW-1:0];
      if (wr_pc & byteenable[0]) pc[7:0] <= writedata[7:0];
      if (wr_pc & byteenable[1]) pc[PC_W-1:8] <= writedata[PC_W-1:8];
      if (exec_done)
      begin
        if (op == OP_CALL)
        begin
          pc <= instr.operand;
          sp <= (sp == 3'(STACK_DEPTH - 1)) ? 3'd0 : sp + 3'd1;
        end
        else if (pc_low_hit) pc <= {pc[PC_W-1:8], res};
        else pc <= pc + 11'd1;
      end
    end
  end

  // storage keeps its contents through power down, so it has no reset
  always_ff @(posedge mclk)
  begin
    if (exec_done & (op == OP_CALL)) stack[sp] <= pc + 11'd1;
    if (wr_mdata) ram[ram_index(mem_addr)] <= writedata[7:0];
    else if (exec_done & dest_mem & ~pc_low_hit) ram[m_addr] <= res;
  end

  // read data mux; unmapped offsets read zero
  wire [31:0] status_word = {20'h00000, pre_second_seen, pre_first_seen,
                             clock_stop, busy, 2'b00, flags};
  wire [31:0] rd_mux =
    (address == OFF_INSTR)    ? {8'h00, instr} :
    (address == OFF_ACC)      ? {24'h000000, acc} :
    (address == OFF_STATUS)   ? status_word :
    (address == OFF_PC)       ? {21'h000000, pc} :
    (address == OFF_MEM_ADDR) ? {26'h0000000, mem_addr} :
    (address == OFF_MEM_DATA) ? {24'h000000, ram[ram_index(mem_addr)]} :
    (address == OFF_STACK)    ? {13'h0000, sp, 5'h00, stack[sp_top]} : 32'h00000000;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset) begin readdata <= 32'h00000000; rd_done <= 1'b0; end
    else if (read & ~rd_done & ~busy) begin readdata <= rd_mux; rd_done <= 1'b1; end
    else rd_done <= 1'b0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  add_result_a: assert property (exec_done && op == OP_ADD_ACC |=>
    acc == $past(acc) + $past(m_val)) else $error("add into acc wrong");
  carry_add_a: assert property (exec_done && op == OP_ADD_CARRY_ACC |=>
    flags.arith_spill_flag == $past(add_sum[8])) else $error("carry out wrong");
  and_keeps_a: assert property (exec_done && (op == OP_AND_ACC || op == OP_AND_IMM) |=>
    $stable(flags[3]) && $stable(flags[1:0])) else $error("and changed flags");
  null_flag_a: assert property (exec_done && upd_null |=>
    flags.result_null_flag == ($past(res) == 8'h00)) else $error("null flag wrong");
  call_jump_a: assert property (exec_done && op == OP_CALL |=>
    pc == $past(instr.operand) && stack[sp_top] == $past(pc) + 11'd1
    && $stable(flags[3:0]) && $stable(flags.power_down_flag)) else $error("call wrong");
  short_cycle_a: assert property (busy && clk_cnt == 4'h0 && total_clks == CLKS_SHORT |->
    busy [*4] ##1 !busy) else $error("one cycle instruction length wrong");
  long_cycle_a: assert property (busy && clk_cnt == 4'h0 && pc_low_hit |->
    busy [*8] ##1 !busy) else $error("pc low write not lengthened");
  lone_pre_a: assert property (exec_done && op == OP_WD_PRE_FIRST && !pre_second_seen |=>
    !wdt_clear && pre_first_seen && $stable(flags.power_down_flag)) else $error("lone preclear");
  pair_pre_a: assert property (exec_done && pre_pair |=>
    wdt_clear && !flags.power_down_flag && !pre_first_seen) else $error("preclear pair");
  halt_entry_a: assert property (pwr_down |=>
    wdt_clear && flags.power_down_flag && clock_stop ##1 $stable(acc)) else $error("power down");
  adjust_mem_a: assert property (exec_done && op == OP_DECIMAL_ADJUST |=>
    $stable(acc) && $stable(flags[3:1])) else $error("decimal adjust touched acc");

endmodule // mie_core

// >>> tb/mie_core_tb_top.sv
/*
  Self-checking bench for the instruction execute core: drives the
  Avalon-MM register port, the watchdog time-out and the wake pin itself.
  Assumes the core package and one 100 MHz clock; no partner model.
*/
`timescale 1ns/10ps

module mie_core_tb_top;
  import mie_pkg::*;

  logic        mclk        = 1'b0;
  logic        reset       = 1'b1;
  logic [4:0]  address     = 5'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0000_0000;
  logic [3:0]  byteenable  = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        wake_pin    = 1'b0;
  logic        wdt_timeout = 1'b0;
  logic        wdt_clear;
  logic        clock_stop;
  int          fail_count  = 0;
  int          num_checks  = 0;
  int          cyc         = 0;
  int          clr_cnt     = 0;
  int          t_done;
  int          t_short;
  int          n;
  logic [31:0] rd;
  logic [63:0] row;

  // rows: opcode, operand, acc, mem, flags in; then acc, mem, flags out
  logic [63:0] tbl [16] = '{
    64'h0401_7F33_0080_330A,
    64'h0121_FF00_0100_0007,
    64'h0221_1020_0110_3100,
    64'h0321_8080_0100_800D,
    64'h0521_0808_0108_1002,
    64'h0621_F00F_0B00_0F0F,
    64'h070C_3C55_040C_5500,
    64'h0821_AA0F_09AA_0A09,
    64'h0F21_11FF_0B11_000F,
    64'h1021_115A_04A5_5A00,
    64'h1221_2201_0022_0004,
    64'h1321_2200_04FF_0000,
    64'h0A21_3377_0B33_000B,
    64'h1121_9A00_009A_0001,
    64'h1121_1200_0212_1802,
    64'h1121_1200_0112_7201
  };

  mie_core dut (
    .mclk(mclk),               .reset(reset),
    .address(address),         .read(read),
    .write(write),             .writedata(writedata),
    .byteenable(byteenable),   .readdata(readdata),
    .waitrequest(waitrequest), .wake_pin(wake_pin),
    .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
    .clock_stop(clock_stop)
  );

  always #5 mclk = ~mclk;

  // cycle count, restart pulses seen, and the hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1)
      clr_cnt <= clr_cnt + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access; an extra edge at the end so the strobe is never re-raised in the same step
  task automatic bus(input logic rw, input logic [4:0] a, input logic [31:0] d);
    address   <= a;
    writedata <= d;
    write     <= rw;
    read      <= ~rw;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
      @(posedge mclk);
    rd     = readdata;
    t_done = cyc;
    write  <= 1'b0;
    read   <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic exec(input logic [4:0] op, input logic [2:0] bs, input logic [10:0] opnd);
    bus(1'b1, OFF_INSTR, {8'h00, op, bs, 5'h00, opnd});
  endtask

  task automatic expire;
    wdt_timeout <= 1'b1;
    @(posedge mclk);
    wdt_timeout <= 1'b0;
    @(posedge mclk);
  endtask

  // the status read stalls until execution ends, so the restart pulse is counted by then
  task automatic wd(input logic [4:0] op, input int pulses, input logic [31:0] bits);
    n = clr_cnt;
    exec(op, 3'h0, 11'h000);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(32'(clr_cnt - n), 32'(pulses));
    chk(rd & 32'h0000_0C30, bits);
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    bus(1'b0, OFF_ACC, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h0000_FFFF, 32'h0000_0000);
    bus(1'b0, 5'h1C, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b1, OFF_MEM_ADDR, 32'h0000_0021);
    // arithmetic and logic table
    for (int i = 0; i < 16; i++)
    begin
      row = tbl[i];
      bus(1'b1, OFF_ACC, {24'h0, row[47:40]});
      bus(1'b1, OFF_MEM_DATA, {24'h0, row[39:32]});
      bus(1'b1, OFF_STATUS, {24'h0, row[31:24]});
      exec(row[60:56], 3'h0, {3'h0, row[55:48]});
      bus(1'b0, OFF_ACC, 32'h0);
      chk(rd, {24'h0, row[23:16]});
      bus(1'b0, OFF_MEM_DATA, 32'h0);
      chk(rd, {24'h0, row[15:8]});
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(rd & 32'h0000_FFFF, {24'h0, row[7:0]});
    end
    // every bit position cleared alone, flags held
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, OFF_MEM_DATA, 32'h0000_00FF);
      bus(1'b1, OFF_STATUS, 32'h0000_0005);
      exec(OP_BIT_ZERO, 3'(i), 11'h021);
      bus(1'b0, OFF_MEM_DATA, 32'h0);
      chk(rd, {24'h0, 8'hFF & ~(8'h01 << i)});
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(rd & 32'h0000_00FF, 32'h0000_0005);
    end
    // two calls back to back, the second waits on the first
    bus(1'b1, OFF_STATUS, 32'h0000_000F);
    bus(1'b1, OFF_PC, 32'h0000_0123);
    exec(OP_CALL, 3'h0, 11'h456);
    exec(OP_CALL, 3'h0, 11'h7FF);
    bus(1'b0, OFF_PC, 32'h0);
    chk(rd & 32'h0000_07FF, 32'h0000_07FF);
    bus(1'b0, OFF_STACK, 32'h0);
    chk(rd & 32'h0007_07FF, 32'h0002_0457);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h0000_00FF, 32'h0000_000F);
    // a result landing in the pc low byte costs one more instruction cycle
    exec(OP_ZERO_MEMORY, 3'h0, 11'h021);
    t_short = t_done;
    bus(1'b0, OFF_ACC, 32'h0);
    t_short = t_done - t_short;
    exec(OP_ZERO_MEMORY, 3'h0, 11'h006);
    n = t_done;
    bus(1'b0, OFF_ACC, 32'h0);
    chk(32'(t_done - n - t_short), 32'(CLKS_PER_ICYCLE));
    // watchdog restart, preclear pairs and power down
    bus(1'b1, OFF_MEM_DATA, 32'h0000_005C);
    expire();
    wd(OP_WD_PRE_FIRST, 0, 32'h0000_0410);
    wd(OP_WD_PRE_FIRST, 0, 32'h0000_0410);
    wd(OP_WD_PRE_SECOND, 1, 32'h0000_0000);
    expire();
    wd(OP_WD_PRE_SECOND, 0, 32'h0000_0810);
    wd(OP_WD_PRE_FIRST, 1, 32'h0000_0000);
    expire();
    wd(OP_WD_RESTART, 1, 32'h0000_0000);
    bus(1'b1, OFF_ACC, 32'h0000_0011);
    wd(OP_POWER_DOWN, 1, 32'h0000_0020);
    chk({31'h0, clock_stop}, 32'h0000_0001);
    exec(OP_ADD_IMM, 3'h0, 11'h001);
    bus(1'b0, OFF_ACC, 32'h0);
    chk(rd, 32'h0000_0011);
    bus(1'b0, OFF_MEM_DATA, 32'h0);
    chk(rd, 32'h0000_005C);
    // wake and clear the power-down flag again
    wake_pin <= 1'b1;
    n = 0;
    while (clock_stop !== 1'b0 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    wake_pin <= 1'b0;
    chk({31'h0, clock_stop}, 32'h0000_0000);
    wd(OP_WD_RESTART, 1, 32'h0000_0000);
    results();
  end

endmodule  // mie_core_tb_top
